// ---- hdl/gfe_defs.vh ----
/*
 * Constants for the input-pin and fan-tach error status bank.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef GFE_DEFS_VH
`define GFE_DEFS_VH

`define GFE_ADDR_INPUT_FLAGS 8'h46
`define GFE_ADDR_FAN_FLAGS   8'h47
`define GFE_RESET_FLAGS      8'h00
`define GFE_FAN_BITS         4
`define GFE_SLEEP_S0         2'h0
`define GFE_SLEEP_S1         2'h1
`define GFE_SLEEP_S3         2'h2
`define GFE_SLEEP_S45        2'h3
`define GFE_FAN_RES_VAL      4'h0
`define GFE_UNMAPPED_READ    8'h00

`endif

// ---- hdl/gfe_flag_bit.v ----
/*
 * One sticky write-one-clear error flag.
 * Assumes a synchronous, active-high reset and a one-cycle clear strobe.
 */
`timescale 1ns/1ns
module gfe_flag_bit (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Condition and control
	input  wire cond_i,
	input  wire mask_i,
	input  wire clr_i,
	// Flag
	output reg  flag_o
);
	wire set_w;

	assign set_w = cond_i & ~mask_i;

	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_w) begin
			// Set wins over a clear in the same cycle; a live unmasked condition blocks the clear
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule // gfe_flag_bit

// ---- hdl/gfe_error_status.v ----
/*
 * Input-pin and fan-tach sticky error status registers with sleep masking.
 * Assumes a byte-wide register port decoded by the serial interface logic
 * outside, and tach counts and limits supplied as plain ports.
 */
`timescale 1ns/1ns
`include "gfe_defs.vh"

// Functional notes
// - Low input pin sets its error flag
// - Input error mask suppresses that flag
// - Tach count above limit sets fan flag
// - Flags masked in S4/5, optionally S1/S3
// - Flags stay set until software clears
// - Writing one clears; zero leaves flag
// - Clear ignored while unmasked condition still present
// - Sleep masks and last-written sleep state apply
module gfe_error_status #(
	parameter TACH_W = 16
) (
	// Clock and reset
	input  wire                  clk_i,
	input  wire                  rst_i,
	// Register port
	input  wire [7:0]            reg_addr_i,
	input  wire                  reg_wr_i,
	input  wire                  reg_rd_i,
	input  wire [7:0]            reg_wdata_i,
	output reg  [7:0]            reg_rdata_o,
	// Pins and measurements
	input  wire [7:0]            general_input_pin_i,
	input  wire [4*TACH_W-1:0]   tach_count_i,
	input  wire [4*TACH_W-1:0]   tach_limit_i,
	// Configuration kept elsewhere in the register map
	input  wire [7:0]            input_error_mask_i,
	input  wire [1:0]            sleep_state_i,
	input  wire                  sleep_mask_s1_i,
	input  wire                  sleep_mask_s3_i,
	// Flags
	output wire [7:0]            input_low_flags_o,
	output wire [3:0]            tach_slow_flags_o
);
	// Sleep gating and register strobes
	wire                sleep_mask_w;
	wire                wr_in_w;
	wire                wr_fan_w;
	// Per-pin set conditions, masks and clear strobes
	wire [7:0]          in_low_w;
	wire [7:0]          in_mask_w;
	wire [7:0]          in_clr_w;
	// Per-channel tach counts and limits
	wire [TACH_W-1:0]   tach1_count_w;
	wire [TACH_W-1:0]   tach2_count_w;
	wire [TACH_W-1:0]   tach3_count_w;
	wire [TACH_W-1:0]   tach4_count_w;
	wire [TACH_W-1:0]   tach1_limit_w;
	wire [TACH_W-1:0]   tach2_limit_w;
	wire [TACH_W-1:0]   tach3_limit_w;
	wire [TACH_W-1:0]   tach4_limit_w;
	wire [3:0]          slow_w;
	wire [3:0]          fan_clr_w;
	// Read path
	reg  [7:0]          rdata_nxt;

	// S4/5 always masks; S1 and S3 only when their enable is set
	assign sleep_mask_w = (sleep_state_i == `GFE_SLEEP_S45) |
		((sleep_state_i == `GFE_SLEEP_S1) & sleep_mask_s1_i) |
		((sleep_state_i == `GFE_SLEEP_S3) & sleep_mask_s3_i);
	assign wr_in_w  = reg_wr_i & (reg_addr_i == `GFE_ADDR_INPUT_FLAGS);
	assign wr_fan_w = reg_wr_i & (reg_addr_i == `GFE_ADDR_FAN_FLAGS);

	assign in_low_w  = ~general_input_pin_i;
	assign in_mask_w = input_error_mask_i | {8{sleep_mask_w}};
	assign in_clr_w  = reg_wdata_i & {8{wr_in_w}};

	// Channel 1 sits in the low bits of the packed buses
	assign tach1_count_w = tach_count_i[0*TACH_W +: TACH_W];
	assign tach2_count_w = tach_count_i[1*TACH_W +: TACH_W];
	assign tach3_count_w = tach_count_i[2*TACH_W +: TACH_W];
	assign tach4_count_w = tach_count_i[3*TACH_W +: TACH_W];
	assign tach1_limit_w = tach_limit_i[0*TACH_W +: TACH_W];
	assign tach2_limit_w = tach_limit_i[1*TACH_W +: TACH_W];
	assign tach3_limit_w = tach_limit_i[2*TACH_W +: TACH_W];
	assign tach4_limit_w = tach_limit_i[3*TACH_W +: TACH_W];

	// Strictly above: a count equal to its limit is no error
	assign slow_w[0] = tach1_count_w > tach1_limit_w;
	assign slow_w[1] = tach2_count_w > tach2_limit_w;
	assign slow_w[2] = tach3_count_w > tach3_limit_w;
	assign slow_w[3] = tach4_count_w > tach4_limit_w;
	// Reserved bits 7:4 have no flag behind them, so writes there go nowhere
	assign fan_clr_w = reg_wdata_i[`GFE_FAN_BITS-1:0] & {`GFE_FAN_BITS{wr_fan_w}};

	// Sleep masking only blocks new sets; flags already set ride through
	gfe_flag_bit u_in0 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[0]),
		.mask_i (in_mask_w[0]),
		.clr_i  (in_clr_w[0]),
		.flag_o (input_low_flags_o[0])
	);

	gfe_flag_bit u_in1 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[1]),
		.mask_i (in_mask_w[1]),
		.clr_i  (in_clr_w[1]),
		.flag_o (input_low_flags_o[1])
	);

	gfe_flag_bit u_in2 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[2]),
		.mask_i (in_mask_w[2]),
		.clr_i  (in_clr_w[2]),
		.flag_o (input_low_flags_o[2])
	);

	gfe_flag_bit u_in3 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[3]),
		.mask_i (in_mask_w[3]),
		.clr_i  (in_clr_w[3]),
		.flag_o (input_low_flags_o[3])
	);

	gfe_flag_bit u_in4 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[4]),
		.mask_i (in_mask_w[4]),
		.clr_i  (in_clr_w[4]),
		.flag_o (input_low_flags_o[4])
	);

	gfe_flag_bit u_in5 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[5]),
		.mask_i (in_mask_w[5]),
		.clr_i  (in_clr_w[5]),
		.flag_o (input_low_flags_o[5])
	);

	gfe_flag_bit u_in6 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[6]),
		.mask_i (in_mask_w[6]),
		.clr_i  (in_clr_w[6]),
		.flag_o (input_low_flags_o[6])
	);

	gfe_flag_bit u_in7 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (in_low_w[7]),
		.mask_i (in_mask_w[7]),
		.clr_i  (in_clr_w[7]),
		.flag_o (input_low_flags_o[7])
	);

	gfe_flag_bit u_fan1 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (slow_w[0]),
		.mask_i (sleep_mask_w),
		.clr_i  (fan_clr_w[0]),
		.flag_o (tach_slow_flags_o[0])
	);

	gfe_flag_bit u_fan2 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (slow_w[1]),
		.mask_i (sleep_mask_w),
		.clr_i  (fan_clr_w[1]),
		.flag_o (tach_slow_flags_o[1])
	);

	gfe_flag_bit u_fan3 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (slow_w[2]),
		.mask_i (sleep_mask_w),
		.clr_i  (fan_clr_w[2]),
		.flag_o (tach_slow_flags_o[2])
	);

	gfe_flag_bit u_fan4 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (slow_w[3]),
		.mask_i (sleep_mask_w),
		.clr_i  (fan_clr_w[3]),
		.flag_o (tach_slow_flags_o[3])
	);

	// Unmapped addresses read as zero; data holds between reads
	always @* begin
		rdata_nxt = reg_rdata_o;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`GFE_ADDR_INPUT_FLAGS: rdata_nxt = input_low_flags_o;
				`GFE_ADDR_FAN_FLAGS:   rdata_nxt = {`GFE_FAN_RES_VAL, tach_slow_flags_o};
				default:               rdata_nxt = `GFE_UNMAPPED_READ;
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= `GFE_RESET_FLAGS;
		end else begin
			reg_rdata_o <= rdata_nxt;
		end
	end
endmodule // gfe_error_status

// ---- sim/gfe_error_status_assertions.sv ----
/*
 * Concurrent checks on the flag bank, seen only through its ports.
 * Assumes the bank's single clock and its synchronous active-high reset.
 */
`timescale 1ns/1ns
module gfe_chk (
	// Clock and reset
	input  logic       clk_i,
	input  logic       rst_i,
	// Register port
	input  logic [7:0] reg_addr_i,
	input  logic       reg_wr_i,
	input  logic       reg_rd_i,
	input  logic [7:0] reg_wdata_i,
	input  logic [7:0] reg_rdata_o,
	// Pins and configuration
	input  logic [7:0] general_input_pin_i,
	input  logic [7:0] input_error_mask_i,
	input  logic [1:0] sleep_state_i,
	// Flags
	input  logic [7:0] input_low_flags_o,
	input  logic [3:0] tach_slow_flags_o
);
	wire [7:0]  p;
	wire [11:0] q;
	wire [7:0]  c;
	wire [11:0] x;

	assign p = input_low_flags_o;
	assign q = {tach_slow_flags_o, p};
	// Unmasked low pins; sleep gating is left out, so this bounds the sets from above
	assign c = ~general_input_pin_i & ~input_error_mask_i;
	// Write-one clear strobes per flag, decoded by address
	assign x = {reg_wdata_i[3:0] & {4{reg_wr_i & (reg_addr_i == 8'h47)}},
		reg_wdata_i & {8{reg_wr_i & (reg_addr_i == 8'h46)}}};

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_set_low: assert property (sleep_state_i == 2'h0 |=> (p & $past(c)) == $past(c))
		else $error("flag not set");
	a_mask_pin: assert property ((p & ~$past(p) & ~$past(c)) == 8'h00)
		else $error("masked flag set");
	a_deep_sleep: assert property (sleep_state_i == 2'h3 |=> (q & ~$past(q)) == 12'h000)
		else $error("flag set asleep");
	a_hold_flag: assert property (!$past(rst_i) |-> (~q & $past(q) & ~$past(x)) == 12'h000)
		else $error("flag lost");
	a_clear_flag: assert property (reg_wr_i && reg_addr_i == 8'h46 |=>
		(p & $past(reg_wdata_i) & ~$past(c)) == 8'h00)
		else $error("flag not cleared");
	a_read_input: assert property (reg_rd_i && reg_addr_i == 8'h46 |=>
		reg_rdata_o == $past(input_low_flags_o))
		else $error("input flags misread");
	a_read_fan: assert property (reg_rd_i && reg_addr_i == 8'h47 |=>
		reg_rdata_o == {4'h0, $past(tach_slow_flags_o)})
		else $error("fan flags misread");
endmodule // gfe_chk
bind gfe_error_status gfe_chk gfe_chk_inst (
	.clk_i               (clk_i),
	.rst_i               (rst_i),
	.reg_addr_i          (reg_addr_i),
	.reg_wr_i            (reg_wr_i),
	.reg_rd_i            (reg_rd_i),
	.reg_wdata_i         (reg_wdata_i),
	.reg_rdata_o         (reg_rdata_o),
	.general_input_pin_i (general_input_pin_i),
	.input_error_mask_i  (input_error_mask_i),
	.sleep_state_i       (sleep_state_i),
	.input_low_flags_o   (input_low_flags_o),
	.tach_slow_flags_o   (tach_slow_flags_o)
);

// ---- sim/gfe_error_status_bench.sv ----
/* Bench for the flag bank; drives every port itself. */
`timescale 1ns/1ns
module gfe_error_status_bench;
	logic clk_i=0,rst_i=1,reg_wr_i=0,reg_rd_i=0,sleep_mask_s1_i=0,sleep_mask_s3_i=0;
	logic [1:0] sleep_state_i=0;
	logic [7:0] reg_addr_i=0,reg_wdata_i=0,general_input_pin_i=8'hFF,input_error_mask_i=0,ei;
	logic [63:0] tach_count_i={4{16'h0010}},tach_limit_i={4{16'h0010}};
	wire [7:0] reg_rdata_o,input_low_flags_o;
	wire [3:0] tach_slow_flags_o;
	logic [3:0] sl,mc,ov,ef;
	int error_cnt=0,comparisons=0,cyc=0;
	// Row: pins, mask, sleep, mask enables, limit drop per channel, input flags, fan flags
	logic [39:0] rows[7]='{40'h0F_0000_5F05,40'h00_F000_A0FA,40'h00_0012_F000,40'h00_0030_F000,
		40'h00_0011_FFFF,40'h00_0021_F000,40'h5A_0022_3A53};
	gfe_error_status gfe_error_status_inst (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.reg_addr_i          (reg_addr_i),
		.reg_wr_i            (reg_wr_i),
		.reg_rd_i            (reg_rd_i),
		.reg_wdata_i         (reg_wdata_i),
		.reg_rdata_o         (reg_rdata_o),
		.general_input_pin_i (general_input_pin_i),
		.tach_count_i        (tach_count_i),
		.tach_limit_i        (tach_limit_i),
		.input_error_mask_i  (input_error_mask_i),
		.sleep_state_i       (sleep_state_i),
		.sleep_mask_s1_i     (sleep_mask_s1_i),
		.sleep_mask_s3_i     (sleep_mask_s3_i),
		.input_low_flags_o   (input_low_flags_o),
		.tach_slow_flags_o   (tach_slow_flags_o)
	);
	always #5 clk_i=~clk_i;
	always @(posedge clk_i) if (++cyc>999) begin error_cnt++; conclude; end
	task chk(input [7:0] s,e); comparisons++;
		if (s!==e) begin error_cnt++; $display("wrong value %0t %h %h",$time,s,e); end
	endtask
	task acc(input [7:0] a,d,input w); {reg_addr_i,reg_wdata_i,reg_wr_i,reg_rd_i}={a,d,w,!w};
		@(posedge clk_i); #1 {reg_wr_i,reg_rd_i}=0; @(posedge clk_i); #1; endtask
	task conclude; $display("%0d errors, %0d checks",error_cnt,comparisons);
		if (error_cnt==0&&comparisons>0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish; endtask
	initial begin
		repeat (20) @(posedge clk_i);
		#1 rst_i=0; chk(input_low_flags_o|tach_slow_flags_o,0);
		for (int i=0;i<7;i++) begin
			{general_input_pin_i,input_error_mask_i,sl,mc,ov,ei,ef}=rows[i];
			{sleep_state_i,sleep_mask_s1_i,sleep_mask_s3_i}={sl[1:0],mc[1:0]};
			// Limit one below the count sets, equal does not
			for (int k=0;k<4;k++) tach_limit_i[k*16+:16]=16'h0010-ov[k];
			@(posedge clk_i); #1 {general_input_pin_i,input_error_mask_i,sleep_state_i}=18'h3_FC00;
			tach_limit_i=tach_count_i;
			acc(8'h46,0,0); chk(reg_rdata_o,ei);
			acc(8'h47,0,0); chk(reg_rdata_o,ef);
			acc(8'h46,8'hFF,1); acc(8'h47,8'hFF,1); chk(input_low_flags_o|tach_slow_flags_o,0);
		end
		// A clear while the pin is still low must lose, seen right after the write edge
		general_input_pin_i=8'hFE; @(posedge clk_i); #1 chk(input_low_flags_o,8'h01);
		{reg_addr_i,reg_wdata_i,reg_wr_i}={8'h46,8'h01,1'b1};
		@(posedge clk_i); #1 chk(input_low_flags_o,8'h01);
		{general_input_pin_i,reg_wdata_i}={8'hFF,8'h00};
		@(posedge clk_i); #1 chk(input_low_flags_o,8'h01);
		{reg_wr_i,reg_rd_i}=2'b01;
		@(posedge clk_i); #1 chk(reg_rdata_o,8'h01);
		reg_addr_i=8'h48;
		@(posedge clk_i); #1 chk(reg_rdata_o,8'h00);
		acc(8'h46,8'h01,1); chk(input_low_flags_o,8'h00);
		// Mid-run reset drops a set flag and beats a read issued with it
		general_input_pin_i=8'h7F; @(posedge clk_i); #1 chk(input_low_flags_o,8'h80);
		{general_input_pin_i,rst_i,reg_addr_i,reg_rd_i}={8'hFF,1'b1,8'h46,1'b1};
		@(posedge clk_i); #1 {rst_i,reg_rd_i}=2'b00;
		chk(input_low_flags_o,8'h00);
		chk(reg_rdata_o,8'h00);
		conclude;
	end
endmodule // gfe_error_status_bench
